/* File: rtl/psc_pkg.sv */
// Purpose: Shared constants, types and decode for the strap and MAC port
//          configuration block.
// Assumes: Strap pin vector order matches the psc_strap_t field order.
// Notes:   Pin index 0 is the lowest station address bit.
package psc_pkg;

  // ************************************************************
  // Strap pins
  // ************************************************************
  localparam int STRAP_W = 13;
  localparam int ADDR_W = 5;
  // Pull defaults: address 00001, speed, duplex and autoneg pulled up
  localparam logic [12:0] STRAP_DEFAULT = 13'h1c01;
  // Edges after reset release before synchronised pins are trusted
  localparam logic [1:0] SETTLE_CYC = 2'h2;

  // ************************************************************
  // Register images
  // ************************************************************
  localparam int CR0_SPEED_BIT = 13;
  localparam int CR0_ANEG_BIT = 12;
  localparam int CR0_DUPLEX_BIT = 8;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam int ADV_10HD_BIT = 5;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_100FD_BIT = 8;

  // ************************************************************
  // MAC port framing
  // ************************************************************
  localparam logic [3:0] SEG_LAST_BIT = 4'h9;
  localparam logic [3:0] SEG_LAST_REP = 4'h9;
  localparam logic [1:0] MII_LAST_STEP = 2'h1;
  localparam logic [1:0] RMII_LAST_STEP = 2'h3;

  typedef struct packed {
    logic autoneg;
    logic duplex;
    logic speed;
    logic back_to_back;
    logic reduced_sel;
    logic isolate;
    logic serial_sel;
    logic loopback;
    logic [4:0] station_address;
  } psc_strap_t;

  typedef enum logic [1:0] {PSC_MII, PSC_RMII, PSC_SMII} psc_mode_t;

  // Serial select outranks reduced select when both are strapped
  function automatic psc_mode_t psc_mode_sel(input logic serial_sel,
                                             input logic reduced_sel);
    if (serial_sel) begin
      return PSC_SMII;
    end
    return reduced_sel ? PSC_RMII : PSC_MII;
  endfunction

endpackage

/* File: rtl/psc_strap_config.sv */
// Purpose: Strap capture at reset release and MAC data port framing
//          (MII, RMII, SMII) for a 10/100 PHY.
// Assumes: mac_clk runs the MAC port; core byte ports are on mac_clk.
// Notes:   Straps are static after capture, so the link side takes them
//          once, qualified by a synchronised valid flag.
// Notes on behaviour
// (RULE1) Sample five station address straps at reset; default address 00001.
// (RULE2) Loopback strap pulled up at reset enables coding loopback.
// (RULE3) Serial port select strap pulled up selects serial MAC mode.
// (RULE4) Isolate strap pulled up keeps the MAC outputs undriven.
// (RULE5) Reduced port strap pulled up selects the two-bit MAC mode.
// (RULE6) Back-to-back strap pulled up enables reduced back-to-back use.
// (RULE7) Speed strap lands in control register 0 bit 13; up means 100.
// (RULE8) Asserted speed strap also sets the advertised speed capability.
// (RULE9) In fiber mode a latched speed 0 disables far-end fault.
// (RULE10) Duplex strap lands in control register 0 bit 8; up means full.
// (RULE11) Duplex strap pulled up also sets advertised duplex capability.
// (RULE12) Autoneg strap lands in control register 0 bit 12; up enables.
// (RULE13) Power-down input low enters power down; high runs normally.
// (RULE14) Fiber enable low keeps fiber off; in fiber it is signal detect.
// (RULE15) Reset must be held low at least 50 us by the controller.
// (RULE16) MII receive nibbles on mac_clk are valid only while rx_dv is high.
// (RULE17) MII transmit nibbles are taken only while tx_en is high.
// (RULE18) RMII receive sends two bits each clock while crs_dv is high.
// (RULE19) RMII transmit accepts two bits each clock while tx_en is high.
// (RULE20) Serial receive sends 10-bit segments, repeated ten times at 10.
// (RULE21) Serial transmit takes 10-bit segments, one of ten sampled at 10.
// (RULE22) Strap pins are inputs during reset, driven once reset ends.
// (RULE23) Straps are captured at reset release and held until next reset.
`timescale 1ns/100ps
`default_nettype none

module psc_strap_config
  import psc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic mac_clk,
  input wire logic [STRAP_W-1:0] strap_pin_i,
  output logic [STRAP_W-1:0] strap_pin_o,
  output logic [STRAP_W-1:0] strap_pin_oe,
  input wire logic [STRAP_W-1:0] strap_func,
  input wire logic fiber_pin_i,
  input wire logic power_down_n,
  output psc_strap_t straps,
  output logic straps_valid,
  output logic [15:0] control_reg0,
  output logic [15:0] advert_reg4,
  output logic fiber_mode,
  output logic far_end_fault_en,
  output logic fiber_signal_detect,
  output logic power_down,
  output psc_mode_t mac_mode,
  input wire logic [7:0] core_rx_byte,
  input wire logic core_rx_valid,
  output logic core_rx_take,
  output logic [7:0] core_tx_byte,
  output logic core_tx_valid,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mac_out_oe,
  output logic smii_sync,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en
);

  // ************************************************************
  // Pin synchronisers (ref_clk)
  // ************************************************************
  logic [STRAP_W-1:0] pin_s1;
  logic [STRAP_W-1:0] pin_s2;
  logic fx_s1;
  logic fx_s2;
  logic pd_s1;
  logic pd_s2;
  logic [1:0] settle;
  logic cap_go;
  psc_strap_t pin_now;

  // Reset values equal the pull defaults, matching pins during reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= STRAP_DEFAULT;
      pin_s2 <= STRAP_DEFAULT;
      fx_s1 <= 1'b0;
      fx_s2 <= 1'b0;
      pd_s1 <= 1'b1;
      pd_s2 <= 1'b1;
    end else begin
      pin_s1 <= strap_pin_i;
      pin_s2 <= pin_s1;
      fx_s1 <= fiber_pin_i;
      fx_s2 <= fx_s1;
      pd_s1 <= power_down_n;
      pd_s2 <= pd_s1;
    end
  end

  // Wait out the synchroniser before trusting pin_s2
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle <= 2'h0;
    end else if (!straps_valid) begin
      settle <= settle + 2'h1;
    end
  end

  assign cap_go = !straps_valid && (settle == SETTLE_CYC);
  assign pin_now = psc_strap_t'(pin_s2);

  // ************************************************************
  // Strap capture
  // ************************************************************
  // One capture per reset; later pin activity is the pin's normal job
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      straps <= psc_strap_t'(STRAP_DEFAULT);
      straps_valid <= 1'b0;
      fiber_mode <= 1'b0;
      mac_mode <= PSC_MII;
    end else if (cap_go) begin
      straps <= pin_now; // RULE1 RULE2 RULE4 RULE6 RULE23
      straps_valid <= 1'b1;
      fiber_mode <= fx_s2; // RULE14
      mac_mode <= psc_mode_sel(pin_now.serial_sel,
                               pin_now.reduced_sel); // RULE3 RULE5
    end
  end

  // Register images built from the same captured sample
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_reg0 <= 16'h0000;
      advert_reg4 <= 16'h0000;
      far_end_fault_en <= 1'b0;
    end else if (cap_go) begin
      control_reg0 <= 16'h0000;
      control_reg0[CR0_SPEED_BIT] <= pin_now.speed; // RULE7
      control_reg0[CR0_ANEG_BIT] <= pin_now.autoneg; // RULE12
      control_reg0[CR0_DUPLEX_BIT] <= pin_now.duplex; // RULE10
      advert_reg4 <= {11'h000, ADV_SELECTOR};
      advert_reg4[ADV_10HD_BIT] <= 1'b1;
      advert_reg4[ADV_10FD_BIT] <= pin_now.duplex; // RULE11
      advert_reg4[ADV_100HD_BIT] <= pin_now.speed; // RULE8
      advert_reg4[ADV_100FD_BIT] <= pin_now.speed & pin_now.duplex;
      far_end_fault_en <= fx_s2 & pin_now.speed; // RULE9
    end
  end

  // Strap pins stay inputs until captured, then carry their function
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_pin_oe <= '0;
      strap_pin_o <= '0;
    end else begin
      strap_pin_oe <= (cap_go || straps_valid) ? '1 : '0; // RULE22
      strap_pin_o <= (cap_go || straps_valid) ? strap_func : '0; // RULE22
    end
  end

  // Power down follows the pin live; fiber detect only in fiber mode
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_down <= 1'b0;
      fiber_signal_detect <= 1'b0;
    end else begin
      power_down <= !pd_s2; // RULE13
      fiber_signal_detect <= fiber_mode & fx_s2; // RULE14
    end
  end

  // ************************************************************
  // Crossing into mac_clk
  // ************************************************************
  logic [1:0] lrst_q;
  logic lrst_n;
  logic lv_s1;
  logic lv_s2;
  logic lpd_s1;
  logic lpd_s2;
  logic l_cfg_ok;
  psc_mode_t l_mode;
  logic l_speed;
  logic l_iso;
  logic l_act;
  logic l_mii;

  // Reset asserts at once, releases on mac_clk
  always_ff @(posedge mac_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  assign lrst_n = lrst_q[1];

  always_ff @(posedge mac_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lv_s1 <= 1'b0;
      lv_s2 <= 1'b0;
      lpd_s1 <= 1'b0;
      lpd_s2 <= 1'b0;
    end else begin
      lv_s1 <= straps_valid;
      lv_s2 <= lv_s1;
      lpd_s1 <= power_down;
      lpd_s2 <= lpd_s1;
    end
  end

  // Multi-bit config is stable long before lv_s2 rises, so sampling it
  // once under that qualifier is safe
  always_ff @(posedge mac_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      l_cfg_ok <= 1'b0;
      l_mode <= PSC_MII;
      l_speed <= 1'b0;
      l_iso <= 1'b1;
      mac_out_oe <= 1'b0;
    end else begin
      if (lv_s2 && !l_cfg_ok) begin
        l_cfg_ok <= 1'b1;
        l_mode <= mac_mode;
        l_speed <= straps.speed;
        l_iso <= straps.isolate;
      end
      mac_out_oe <= l_cfg_ok && !l_iso; // RULE4
    end
  end

  assign l_act = l_cfg_ok && !lpd_s2;
  assign l_mii = (l_mode == PSC_MII);

  // ************************************************************
  // Serial segment timing
  // ************************************************************
  logic [3:0] seg_bit;
  logic [3:0] seg_rep;
  logic seg_new;

  // At 10 Mb/s a segment is sent ten times before the next byte
  always_ff @(posedge mac_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      seg_bit <= 4'h0;
      seg_rep <= 4'h0;
      smii_sync <= 1'b0;
    end else begin
      smii_sync <= l_act && (l_mode == PSC_SMII) && (seg_bit == 4'h0);
      if (seg_bit == SEG_LAST_BIT) begin
        seg_bit <= 4'h0;
        if (l_speed || seg_rep == SEG_LAST_REP) begin
          seg_rep <= 4'h0;
        end else begin
          seg_rep <= seg_rep + 4'h1; // RULE20
        end
      end else begin
        seg_bit <= seg_bit + 4'h1;
      end
    end
  end

  assign seg_new = (seg_bit == 4'h0) && (seg_rep == 4'h0);

  // ************************************************************
  // Receive toward the MAC
  // ************************************************************
  logic [9:0] rx_sh;
  logic [9:0] rx_seg;
  logic [1:0] rx_cnt;
  logic [9:0] next_seg;

  // Segment layout: bit 0 carrier, bit 1 data valid, bits 9:2 byte
  assign next_seg = core_rx_valid ? {core_rx_byte, 2'h3} : 10'h000;

  always_ff @(posedge mac_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_sh <= 10'h000;
      rx_seg <= 10'h000;
      rx_cnt <= 2'h0;
      mii_rxd <= 4'h0;
      mii_rx_dv <= 1'b0;
      core_rx_take <= 1'b0;
    end else begin
      core_rx_take <= 1'b0;
      if (!l_act) begin
        rx_cnt <= 2'h0;
        mii_rxd <= 4'h0;
        mii_rx_dv <= 1'b0;
      end else if (l_mode == PSC_SMII) begin
        mii_rx_dv <= 1'b0;
        if (seg_new) begin
          rx_seg <= next_seg;
          rx_sh <= {1'b0, next_seg[9:1]};
          mii_rxd <= {3'h0, next_seg[0]};
          core_rx_take <= core_rx_valid; // RULE20
        end else if (seg_bit == 4'h0) begin
          rx_sh <= {1'b0, rx_seg[9:1]};
          mii_rxd <= {3'h0, rx_seg[0]}; // RULE20
        end else begin
          rx_sh <= {1'b0, rx_sh[9:1]};
          mii_rxd <= {3'h0, rx_sh[0]};
        end
      end else if (rx_cnt == 2'h0) begin
        if (core_rx_valid) begin
          core_rx_take <= 1'b1;
          mii_rx_dv <= 1'b1; // RULE16 RULE18
          if (l_mii) begin
            mii_rxd <= core_rx_byte[3:0];
            rx_sh <= {6'h00, core_rx_byte[7:4]};
            rx_cnt <= MII_LAST_STEP;
          end else begin
            mii_rxd <= {2'h0, core_rx_byte[1:0]};
            rx_sh <= {4'h0, core_rx_byte[7:2]};
            rx_cnt <= RMII_LAST_STEP;
          end
        end else begin
          mii_rx_dv <= 1'b0;
          mii_rxd <= 4'h0;
        end
      end else begin
        rx_cnt <= rx_cnt - 2'h1;
        if (l_mii) begin
          mii_rxd <= rx_sh[3:0];
          rx_sh <= {4'h0, rx_sh[9:4]};
        end else begin
          mii_rxd <= {2'h0, rx_sh[1:0]};
          rx_sh <= {2'h0, rx_sh[9:2]};
        end
      end
    end
  end

  ap_mii_rx_a: assert property (@(posedge mac_clk) disable iff (!lrst_n)
    (l_mii && l_act && core_rx_take) |-> mii_rx_dv ##1 mii_rx_dv) // RULE16
    else $error("MII receive nibble pair not framed by rx_dv");

  ap_rmii_rx_a: assert property (@(posedge mac_clk) disable iff (!lrst_n)
    (l_mode == PSC_RMII && l_act && core_rx_take) |->
    mii_rx_dv [*4]) // RULE18
    else $error("RMII receive byte not four dibits under crs_dv");

  ap_seg_repeat_a: assert property (@(posedge mac_clk) disable iff (!lrst_n)
    (l_act && l_mode == PSC_SMII && seg_bit == 4'h0 && seg_rep != 4'h0) |=>
    (mii_rxd[0] == $past(rx_seg[0]) && $stable(rx_seg))) // RULE20
    else $error("serial receive segment not repeated");

  // ************************************************************
  // Transmit from the MAC
  // ************************************************************
  logic [7:0] tx_acc;
  logic [1:0] tx_cnt;
  logic [8:0] tx_seg;
  logic [3:0] tx_idx;
  logic [7:0] next_acc;
  logic [1:0] tx_last;

  // Bit 0 of a serial segment is the one presented while smii_sync is high
  assign tx_idx = (seg_bit == 4'h0) ? SEG_LAST_BIT : seg_bit - 4'h1;
  assign next_acc = l_mii ? {mii_txd, tx_acc[7:4]} :
                            {mii_txd[1:0], tx_acc[7:2]};
  assign tx_last = l_mii ? MII_LAST_STEP : RMII_LAST_STEP;

  // A partial byte is dropped when tx_en falls mid byte
  always_ff @(posedge mac_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      tx_acc <= 8'h00;
      tx_cnt <= 2'h0;
      tx_seg <= 9'h000;
      core_tx_byte <= 8'h00;
      core_tx_valid <= 1'b0;
    end else begin
      core_tx_valid <= 1'b0;
      if (!l_act) begin
        tx_cnt <= 2'h0;
      end else if (l_mode == PSC_SMII) begin
        if (tx_idx == SEG_LAST_BIT) begin
          // Segment layout: bit 0 error, bit 1 enable, bits 9:2 byte
          if ((l_speed || seg_rep == 4'h1) && tx_seg[1]) begin
            core_tx_byte <= {mii_txd[0], tx_seg[8:2]}; // RULE21
            core_tx_valid <= 1'b1;
          end
        end else begin
          tx_seg[tx_idx[3:0]] <= mii_txd[0];
        end
      end else if (mii_tx_en) begin
        tx_acc <= next_acc; // RULE17 RULE19
        if (tx_cnt == tx_last) begin
          tx_cnt <= 2'h0;
          core_tx_byte <= next_acc;
          core_tx_valid <= 1'b1;
        end else begin
          tx_cnt <= tx_cnt + 2'h1;
        end
      end else begin
        tx_cnt <= 2'h0;
      end
    end
  end

  ap_mii_tx_a: assert property (@(posedge mac_clk) disable iff (!lrst_n)
    (l_mii && l_act && mii_tx_en && tx_cnt == 2'h1) |=>
    (core_tx_valid && core_tx_byte[7:4] == $past(mii_txd))) // RULE17
    else $error("MII transmit nibble pair not assembled");

  ap_rmii_tx_a: assert property (@(posedge mac_clk) disable iff (!lrst_n)
    (l_mode == PSC_RMII && l_act && !mii_tx_en) |=>
    !core_tx_valid) // RULE19
    else $error("RMII transmit byte emitted without tx_en");

  // ************************************************************
  // Strap checks (ref_clk)
  // ************************************************************
  ap_strap_cap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(straps_valid) |-> straps == psc_strap_t'($past(pin_s2))) // RULE1
    else $error("straps differ from sampled pins");

  ap_strap_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (straps_valid && $past(straps_valid)) |->
    ($stable(straps) && $stable(control_reg0))) // RULE23
    else $error("captured straps changed after capture");

  ap_pin_dir_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    straps_valid |=> (strap_pin_oe == '1 && strap_pin_o ==
    $past(strap_func))) // RULE22
    else $error("strap pin not driven after capture");

  ap_speed_img_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    straps_valid |-> (control_reg0[CR0_SPEED_BIT] == straps.speed &&
    advert_reg4[ADV_100HD_BIT] == straps.speed)) // RULE7 RULE8
    else $error("speed image mismatch");

  ap_duplex_img_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    straps_valid |-> (control_reg0[CR0_DUPLEX_BIT] == straps.duplex &&
    control_reg0[CR0_ANEG_BIT] == straps.autoneg)) // RULE10 RULE12
    else $error("duplex or autoneg image mismatch");

  ap_fault_en_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    straps_valid |-> far_end_fault_en == (fiber_mode &&
    straps.speed)) // RULE9
    else $error("far-end fault enable mismatch");

  ap_power_down_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(pd_s2) |=> power_down) // RULE13
    else $error("power down not entered");

  ap_fiber_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !fiber_mode |=> !fiber_signal_detect) // RULE14
    else $error("signal detect outside fiber mode");

endmodule

`default_nettype wire

/* File: bench/psc_mac_model.sv */
// Purpose: MAC partner on the MII data port of the strap block.
// Assumes: MII mode, nibbles low first, one nibble per mac_clk.
// Notes:   Transmit data is left inverted after tx_en falls.
`timescale 1ns/100ps
`default_nettype none

module psc_mac_model (
  input wire logic mac_clk,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_rx_dv,
  output logic [3:0] mii_txd,
  output logic mii_tx_en
);
  logic [3:0] low_nib;
  logic rx_half;
  logic [15:0] rx_log;
  int rx_bytes;

  initial begin
    mii_txd = 4'h0;
    mii_tx_en = 1'b0;
    rx_half = 1'b0;
    rx_log = 16'h0000;
    rx_bytes = 0;
  end

  // Nibbles count only while rx_dv is high; pairing restarts when low
  always @(posedge mac_clk) begin
    if (mii_rx_dv === 1'b1) begin
      if (!rx_half) begin
        low_nib <= mii_rxd;
      end else begin
        rx_log <= {rx_log[7:0], mii_rxd, low_nib};
        rx_bytes <= rx_bytes + 1;
      end
      rx_half <= ~rx_half;
    end else begin
      rx_half <= 1'b0;
    end
  end

  // One byte after gap idle cycles; data inverted once released
  task automatic send_byte(input logic [7:0] b, input int gap);
    repeat (gap) @(negedge mac_clk);
    mii_tx_en = 1'b1;
    mii_txd = b[3:0];
    @(negedge mac_clk);
    mii_txd = b[7:4];
    @(negedge mac_clk);
    mii_tx_en = 1'b0;
    mii_txd = ~b[7:4];
  endtask
endmodule

`default_nettype wire

/* File: bench/psc_strap_config_tb.sv */
// Purpose: Self-checking bench for strap capture and the MII data port.
// Assumes: Reset spans several mac_clk edges so the link side resets too.
// Notes:   The last configuration is the default one, used for traffic.
`timescale 1ns/100ps
`default_nettype none

module psc_strap_config_tb;
  import psc_pkg::*;

  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic ref_clk, mac_clk, arst_n, fiber_pin_i, power_down_n;
  logic [12:0] strap_pin_i, strap_pin_o, strap_pin_oe;
  logic [12:0] strap_func;
  psc_strap_t straps, s;
  psc_mode_t mac_mode;
  logic straps_valid, fiber_mode, far_end_fault_en, fiber_signal_detect;
  logic [15:0] control_reg0, advert_reg4;
  logic power_down, core_rx_valid, core_rx_take, core_tx_valid;
  logic [7:0] core_rx_byte, core_tx_byte;
  logic [3:0] mii_rxd, mii_txd;
  logic mii_rx_dv, mac_out_oe, mii_tx_en, smii_sync;
  int fails, check_count, tx_pulses, n;
  logic [12:0] cfg [3] = '{13'h0b3a, 13'h15df, 13'h1c01};
  logic fib [3] = '{1'b1, 1'b1, 1'b0};

  psc_strap_config psc_strap_config_inst (.ref_clk(ref_clk),
    .arst_n(arst_n), .mac_clk(mac_clk), .strap_pin_i(strap_pin_i),
    .strap_pin_o(strap_pin_o), .strap_pin_oe(strap_pin_oe),
    .strap_func(strap_func), .fiber_pin_i(fiber_pin_i),
    .power_down_n(power_down_n), .straps(straps),
    .straps_valid(straps_valid), .control_reg0(control_reg0),
    .advert_reg4(advert_reg4), .fiber_mode(fiber_mode),
    .far_end_fault_en(far_end_fault_en),
    .fiber_signal_detect(fiber_signal_detect), .power_down(power_down),
    .mac_mode(mac_mode), .core_rx_byte(core_rx_byte),
    .core_rx_valid(core_rx_valid), .core_rx_take(core_rx_take),
    .core_tx_byte(core_tx_byte), .core_tx_valid(core_tx_valid),
    .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mac_out_oe(mac_out_oe),
    .smii_sync(smii_sync), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en));

  psc_mac_model psc_mac_model_inst (.mac_clk(mac_clk), .mii_rxd(mii_rxd),
    .mii_rx_dv(mii_rx_dv), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en));

  // ************************************************************
  // Clocks, tasks and watchdog
  // ************************************************************
  // Link clock offset so its edges never line up with ref_clk
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    mac_clk = 1'b0;
    #1.3;
    forever #7.5 mac_clk = ~mac_clk;
  end

  // Counts every transmit byte, so stray nibbles would show up
  always @(posedge mac_clk) begin
    if (core_tx_valid === 1'b1) begin
      tx_pulses <= tx_pulses + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait for the take pulse at a falling mac_clk edge
  task automatic wait_take;
    n = 0;
    do begin
      @(negedge mac_clk);
      n++;
    end while (core_rx_take !== 1'b1 && n < 20);
    if (core_rx_take !== 1'b1) begin
      fails++;
      $display("ERROR %0t no take", $time);
    end
  endtask

  // Three 50 us resets plus traffic take about 152 us
  initial begin
    #250000;
    fails++;
    close_out();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    arst_n = 1'b0;
    strap_pin_i = 13'h1c01;
    strap_func = 13'h0a5a;
    fiber_pin_i = 1'b0;
    power_down_n = 1'b1;
    core_rx_byte = 8'h00;
    core_rx_valid = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      s = psc_strap_t'(cfg[i]);
      @(negedge ref_clk);
      arst_n = 1'b0;
      strap_pin_i = cfg[i];
      fiber_pin_i = fib[i];
      // Full 50 us reset pulse, as the controller must give
      repeat (10000) @(negedge ref_clk);
      check(strap_pin_oe, 16'h0000);
      arst_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      check(straps_valid, 16'h0001);
      check(strap_pin_oe, 16'h1fff);
      check(strap_pin_o, strap_func);
      check(control_reg0, {2'h0, s.speed, s.autoneg, 3'h0, s.duplex,
        8'h00});
      check(advert_reg4, {7'h00, s.speed & s.duplex, s.speed, s.duplex,
        1'b1, ADV_SELECTOR});
      check(mac_mode, s.serial_sel ? PSC_SMII : (s.reduced_sel ?
        PSC_RMII : PSC_MII));
      check(fiber_mode, fib[i]);
      check(far_end_fault_en, fib[i] & s.speed);
      // Later pin activity must not disturb the captured values
      fiber_pin_i = 1'b1;
      strap_pin_i = ~cfg[i];
      strap_func = ~strap_func;
      repeat (40) @(negedge ref_clk);
      check(strap_pin_o, strap_func);
      check(fiber_signal_detect, fib[i]);
      check(straps, cfg[i]);
      check(mac_out_oe, !s.isolate);
      // Segment sync marks one cycle in ten, only in serial mode
      n = 0;
      repeat (20) begin
        @(negedge mac_clk);
        n += (smii_sync === 1'b1);
      end
      check(16'(n), s.serial_sel ? 16'h0002 : 16'h0000);
      $display("strap test %0d done", i);
    end
    // Two receive bytes back to back
    @(negedge mac_clk);
    core_rx_byte = 8'h5a;
    core_rx_valid = 1'b1;
    wait_take();
    core_rx_byte = 8'hc3;
    wait_take();
    core_rx_valid = 1'b0;
    repeat (6) @(negedge mac_clk);
    check(psc_mac_model_inst.rx_log, 16'h5ac3);
    check(psc_mac_model_inst.rx_bytes, 16'h0002);
    check(mii_rx_dv, 16'h0000);
    $display("receive test done");
    // Slow transmit byte; idle nibbles before and after it are ignored
    fork
      psc_mac_model_inst.send_byte(8'h96, 3);
    join_none
    n = 0;
    do begin
      @(negedge mac_clk);
      n++;
    end while (core_tx_valid !== 1'b1 && n < 20);
    check(core_tx_byte, 16'h0096);
    repeat (10) @(negedge mac_clk);
    check(tx_pulses, 16'h0001);
    $display("transmit test done");
    @(negedge ref_clk);
    power_down_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    check(power_down, 16'h0001);
    power_down_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    check(power_down, 16'h0000);
    $display("power down test done");
    close_out();
  end
endmodule

`default_nettype wire
